/* File: rtl/overlay_defs.svh */
// Constants for the configuration-overlay identify handler and its host end.
// Assumes it is included by bare name from the rtl files.
`ifndef OVERLAY_DEFS_SVH
`define OVERLAY_DEFS_SVH
// Taskfile register addresses on the link (3-bit register select)
`define TF_DATA 3'h0
`define TF_FEATURE 3'h1
`define TF_COUNT 3'h2
`define TF_BLOCK 3'h3
`define TF_TRK_LO 3'h4
`define TF_TRK_HI 3'h5
`define TF_UNIT 3'h6
`define TF_CMD 3'h7
// Command and feature codes
`define OPC_OVERLAY 8'hB1
`define FEAT_RESTORE 8'hC0
`define FEAT_FREEZE 8'hC1
`define FEAT_IDENTIFY 8'hC2
`define FEAT_SET 8'hC3
// Status bit positions
`define ST_BUSY 7
`define ST_READY 6
`define ST_FAULT 5
`define ST_DREQ 3
`define ST_ERR 0
`define ST_RESET 8'h40
`define ER_ABORT 2
`define UNIT_SEL_BIT 4
// Structure layout
`define STRUCT_REV 16'h0001
`define SIGNATURE 8'hA5
`define LAST_WORD 8'hFF
`define W_MDMA 8'h01
`define W_UDMA 8'h02
`define W_LBA0 8'h03
`define W_LBA3 8'h06
`define W_FEAT 8'h07
`define MDMA_MASK 16'h0007
`define UDMA_MASK 16'h003F
`define FEAT_MASK 16'h01FF
// Host controller Avalon register offsets (byte addresses)
`define HR_CTRL 4'h0
`define HR_STATUS 4'h4
`define HR_IRQ_STAT 4'h8
`define HR_IRQ_MASK 4'hC
`endif

/* File: rtl/overlay_pkg.sv */
// Types shared by the overlay identify device and host ends.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package overlay_pkg;
   typedef enum logic [1:0] {
      DEV_IDLE = 2'b00, // Waiting for a command
      DEV_SEND = 2'b01, // Streaming structure words
      DEV_DONE = 2'b10 // Completion posting
   } dev_state_t;
   typedef enum logic [2:0] {
      H_IDLE = 3'b000, // Waiting for a software start
      H_FEAT = 3'b001, // Writing feature selector
      H_UNIT = 3'b010, // Writing unit select
      H_CMD = 3'b011, // Writing opcode
      H_POLL = 3'b100, // Reading status
      H_READ = 3'b101, // Reading data words
      H_FIN = 3'b110 // Posting result
   } host_state_t;
endpackage
`default_nettype wire

/* File: rtl/tf_link_if.sv */
// Parallel taskfile link between host adapter and device.
// Assumes both ends share one clock; transfers are single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
interface tf_link_if;
   logic [2:0] addr; // Register select
   logic wr; // Host write strobe
   logic rd; // Host read strobe, data back next cycle
   logic [15:0] wdata; // Host write data
   logic [15:0] rdata; // Device read data
   logic rvalid; // Device read data valid pulse
   modport host (output addr, wr, rd, wdata, input rdata, rvalid);
   modport device (input addr, wr, rd, wdata, output rdata, rvalid);
endinterface
`default_nettype wire

/* File: rtl/overlay_device.sv */
// Device end: taskfile registers and configuration-overlay identify command.
// Assumes host only reads the data port while the data-request flag is set.
`timescale 1ns/1ps
`default_nettype none
`include "overlay_defs.svh"
module overlay_device
   import overlay_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic CE,
   input wire logic POWER_UP, // Power-on pulse, only thing clearing freeze lock
   input wire logic SUPPORTED, // Overlay feature set implemented
   input wire logic FAULT, // Device fault condition
   input wire logic [15:0] FULL_MDMA, // Full multiword DMA capability
   input wire logic [15:0] FULL_UDMA, // Full Ultra DMA capability
   input wire logic [15:0] FULL_FEAT, // Full feature capability
   input wire logic [63:0] NATIVE_MAX, // Factory maximum address
   output logic SET_REQ, // Set request decoded, pulse
   output logic FROZEN, // Freeze lock state
   tf_link_if.device link
);
   dev_state_t state, next_state; // Command sequencer
   logic [7:0] feature, next_feature; // Feature selector
   logic [7:0] unit, next_unit; // Unit select
   logic [7:0] status, next_status; // Condition flags
   logic [7:0] errreg, next_errreg; // Fault report
   logic [7:0] widx, next_widx; // Word index into structure
   logic [7:0] csum, next_csum; // Running byte sum
   logic frozen, next_frozen; // Freeze lock
   logic set_req, next_set_req;
   logic [15:0] rdata, next_rdata;
   logic rvalid, next_rvalid;
   logic [15:0] word; // Structure word at widx
   logic opc_wr; // Opcode write this cycle

   assign link.rdata = rdata;
   assign link.rvalid = rvalid;
   assign SET_REQ = set_req;
   assign FROZEN = frozen;
   assign opc_wr = link.wr && link.addr == `TF_CMD && link.wdata[7:0] == `OPC_OVERLAY;

   // Structure word mux; built from full capability inputs, never reduced view
   always_comb begin
      word = 16'h0000; // Reserved words read zero
      if (widx == 8'h00) begin
         word = `STRUCT_REV;
      end else if (widx == `W_MDMA) begin
         word = FULL_MDMA & `MDMA_MASK;
      end else if (widx == `W_UDMA) begin
         word = FULL_UDMA & `UDMA_MASK;
      end else if (widx >= `W_LBA0 && widx <= `W_LBA3) begin
         word = NATIVE_MAX[{widx[1:0] + 2'h1, 4'h0} +: 16];
      end else if (widx == `W_FEAT) begin
         word = FULL_FEAT & `FEAT_MASK;
      end else if (widx == `LAST_WORD) begin
         // Two's complement of sum including signature
         word = {8'(8'h00 - csum - `SIGNATURE), `SIGNATURE};
      end
   end

   // Next-state logic for the command sequencer
   always_comb begin
      next_state = state;
      next_feature = feature;
      next_unit = unit;
      next_status = status;
      next_errreg = errreg;
      next_widx = widx;
      next_csum = csum;
      next_frozen = frozen;
      next_set_req = 1'b0;
      next_rdata = rdata;
      next_rvalid = 1'b0;
      // Register reads answer next cycle
      if (link.rd) begin
         next_rvalid = 1'b1;
         case (link.addr)
            `TF_DATA: next_rdata = word;
            `TF_FEATURE: next_rdata = {8'h00, feature};
            `TF_UNIT: next_rdata = {8'h00, unit};
            `TF_CMD: next_rdata = {8'h00, status};
            `TF_COUNT: next_rdata = {8'h00, errreg};
            default: next_rdata = 16'h0000;
         endcase
      end
      case (state)
         DEV_IDLE: begin
            if (link.wr && link.addr == `TF_FEATURE) begin
               next_feature = link.wdata[7:0];
            end
            if (link.wr && link.addr == `TF_UNIT) begin
               next_unit = link.wdata[7:0];
            end
            if (opc_wr) begin
               next_status = 8'h00;
               next_status[`ST_BUSY] = 1'b1;
               next_errreg = 8'h00;
               if (!SUPPORTED || frozen) begin
                  next_state = DEV_DONE;
                  next_errreg[`ER_ABORT] = 1'b1;
               end else if (feature == `FEAT_IDENTIFY) begin
                  next_state = DEV_SEND;
                  next_widx = 8'h00;
                  next_csum = 8'h00;
               end else if (feature == `FEAT_SET) begin
                  next_set_req = 1'b1; // Data-out handled elsewhere
                  next_state = DEV_DONE;
               end else if (feature == `FEAT_FREEZE) begin
                  next_frozen = 1'b1;
                  next_state = DEV_DONE;
               end else if (feature == `FEAT_RESTORE) begin
                  next_state = DEV_DONE;
               end else begin
                  next_errreg[`ER_ABORT] = 1'b1; // Unknown sub-command
                  next_state = DEV_DONE;
               end
            end
         end
         DEV_SEND: begin
            // Ready to stream: data request up, busy down
            next_status[`ST_BUSY] = 1'b0;
            next_status[`ST_DREQ] = 1'b1;
            if (link.rd && link.addr == `TF_DATA) begin
               next_csum = 8'(csum + word[7:0] + word[15:8]);
               if (widx == `LAST_WORD) begin
                  next_state = DEV_DONE;
               end else begin
                  next_widx = 8'(widx + 8'h01);
               end
            end
         end
         DEV_DONE: begin
            next_status = 8'h00;
            next_status[`ST_READY] = 1'b1;
            next_status[`ST_FAULT] = errreg[`ER_ABORT] & FAULT;
            next_status[`ST_ERR] = |errreg;
            next_state = DEV_IDLE;
         end
         default: next_state = DEV_IDLE;
      endcase
   end

   // Register stage; freeze lock ignores RST, only power-up clears it
   always_ff @(posedge CLK_SYS) begin
      if (POWER_UP) begin
         frozen <= 1'b0;
      end else if (CE) begin
         frozen <= next_frozen;
      end
      if (RST) begin
         state <= DEV_IDLE;
         feature <= 8'h00;
         unit <= 8'h00;
         status <= `ST_RESET; // Ready, nothing pending
         errreg <= 8'h00;
         widx <= 8'h00;
         csum <= 8'h00;
         set_req <= 1'b0;
         rdata <= 16'h0000;
         rvalid <= 1'b0;
      end else if (CE) begin
         state <= next_state;
         feature <= next_feature;
         unit <= next_unit;
         status <= next_status;
         errreg <= next_errreg;
         widx <= next_widx;
         csum <= next_csum;
         set_req <= next_set_req;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end
endmodule // overlay_device
`default_nettype wire

/* File: rtl/overlay_host.sv */
// Host end: Avalon-MM slave for software, drives identify over the taskfile link.
// Assumes the device answers each read strobe on the next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "overlay_defs.svh"
module overlay_host
   import overlay_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic CE,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic IRQ,
   tf_link_if.host link
);
   host_state_t state, next_state;
   logic [7:0] unit_bit, next_unit_bit; // Device select for next command
   logic [7:0] stat, next_stat; // Last device status
   logic [7:0] sum, next_sum; // Byte sum of received block
   logic [8:0] cnt, next_cnt; // Words received
   logic [1:0] irqs, next_irqs; // Done, bad-checksum sticky bits
   logic [1:0] mask, next_mask;
   logic [2:0] addr, next_addr;
   logic wr, next_wr, rd, next_rd, pend, next_pend;
   logic [15:0] wdata, next_wdata;
   logic [31:0] rdat, next_rdat;
   logic wait_r, next_wait, irq_r, next_irq;

   assign link.addr = addr;
   assign link.wr = wr;
   assign link.rd = rd;
   assign link.wdata = wdata;
   assign AVS_READDATA = rdat;
   assign AVS_WAITREQUEST = wait_r;
   assign IRQ = irq_r;

   // Sequencer and bus slave next values
   always_comb begin
      next_state = state;
      next_unit_bit = unit_bit;
      next_stat = stat;
      next_sum = sum;
      next_cnt = cnt;
      next_irqs = irqs;
      next_mask = mask;
      next_addr = addr;
      next_wr = 1'b0;
      next_rd = 1'b0;
      next_pend = 1'b0;
      next_wdata = wdata;
      next_rdat = rdat;
      // Slave answers on the second cycle: waitrequest high then low
      next_wait = 1'b1;
      if ((AVS_READ || AVS_WRITE) && wait_r) begin
         next_wait = 1'b0;
         if (AVS_WRITE && AVS_ADDRESS == `HR_CTRL) begin
            next_unit_bit = {3'h0, AVS_WRITEDATA[1], 4'h0};
            if (AVS_WRITEDATA[0] && state == H_IDLE) begin
               next_state = H_FEAT;
            end
         end
         if (AVS_WRITE && AVS_ADDRESS == `HR_IRQ_MASK) begin
            next_mask = AVS_WRITEDATA[1:0];
         end
         case (AVS_ADDRESS)
            `HR_CTRL: next_rdat = {30'h0, unit_bit[`UNIT_SEL_BIT], state == H_IDLE ? 1'b0 : 1'b1};
            `HR_STATUS: next_rdat = {15'h0, cnt, stat};
            `HR_IRQ_STAT: next_rdat = {30'h0, irqs};
            `HR_IRQ_MASK: next_rdat = {30'h0, mask};
            default: next_rdat = 32'h0;
         endcase
      end else if (AVS_READ || AVS_WRITE) begin
         next_wait = 1'b1;
      end
      // Registers loaded before the opcode write
      case (state)
         H_IDLE: ;
         H_FEAT: begin
            next_addr = `TF_FEATURE;
            next_wdata = {8'h00, `FEAT_IDENTIFY};
            next_wr = 1'b1;
            next_state = H_UNIT;
         end
         H_UNIT: begin
            next_addr = `TF_UNIT;
            next_wdata = {8'h00, unit_bit};
            next_wr = 1'b1;
            next_state = H_CMD;
         end
         H_CMD: begin
            next_addr = `TF_CMD;
            next_wdata = {8'h00, `OPC_OVERLAY};
            next_wr = 1'b1;
            next_sum = 8'h00;
            next_cnt = 9'h000;
            next_state = H_POLL;
         end
         H_POLL: begin
            if (!rd && !pend) begin
               next_addr = `TF_CMD;
               next_rd = 1'b1;
            end else begin
               next_pend = rd;
            end
            if (link.rvalid) begin
               next_stat = link.rdata[7:0];
               if (link.rdata[`ST_DREQ]) begin
                  next_state = H_READ;
               end else if (!link.rdata[`ST_BUSY] && link.rdata[`ST_READY]) begin
                  next_state = H_FIN;
               end
            end
         end
         H_READ: begin
            if (!rd && !pend) begin
               next_addr = `TF_DATA;
               next_rd = 1'b1;
            end else begin
               next_pend = rd;
            end
            if (link.rvalid) begin
               next_sum = 8'(sum + link.rdata[7:0] + link.rdata[15:8]);
               next_cnt = 9'(cnt + 9'h001);
               if (cnt == {1'b0, `LAST_WORD}) begin
                  next_state = H_POLL;
               end
            end
         end
         H_FIN: begin
            next_irqs[0] = 1'b1;
            if (cnt != 9'h000 && sum != 8'h00) begin
               next_irqs[1] = 1'b1;
            end
            next_state = H_IDLE;
         end
         default: next_state = H_IDLE;
      endcase
      // Write-one-to-clear; a same-cycle set wins
      if (AVS_WRITE && wait_r && AVS_ADDRESS == `HR_IRQ_STAT) begin
         next_irqs = next_irqs & ~(AVS_WRITEDATA[1:0] & irqs);
         if (state == H_FIN) begin
            next_irqs[0] = 1'b1;
            next_irqs[1] = next_irqs[1] | (cnt != 9'h000 && sum != 8'h00);
         end
      end
      next_irq = |(next_irqs & next_mask);
   end

   // Register stage
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state <= H_IDLE;
         unit_bit <= 8'h00;
         stat <= 8'h00;
         sum <= 8'h00;
         cnt <= 9'h000;
         irqs <= 2'h0;
         mask <= 2'h0;
         addr <= 3'h0;
         wr <= 1'b0;
         rd <= 1'b0;
         pend <= 1'b0;
         wdata <= 16'h0000;
         rdat <= 32'h0;
         wait_r <= 1'b1;
         irq_r <= 1'b0;
      end else if (CE) begin
         state <= next_state;
         unit_bit <= next_unit_bit;
         stat <= next_stat;
         sum <= next_sum;
         cnt <= next_cnt;
         irqs <= next_irqs;
         mask <= next_mask;
         addr <= next_addr;
         wr <= next_wr;
         rd <= next_rd;
         pend <= next_pend;
         wdata <= next_wdata;
         rdat <= next_rdat;
         wait_r <= next_wait;
         irq_r <= next_irq;
      end
   end
endmodule // overlay_host
`default_nettype wire

/* File: tb/config_overlay_identify_cmd_props.sv */
// Checker for the taskfile link between the host end and the device end.
// Assumes it is instantiated beside the link in the bench, on the link's clock.
`timescale 1ns/1ps
`default_nettype none
`include "overlay_defs.svh"
module config_overlay_identify_cmd_props (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [2:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic rvalid
);
   logic [8:0] data_cnt; // Data words returned since the last opcode
   logic [8:0] next_data_cnt;
   logic data_rd; // Last cycle read the data port
   logic next_data_rd;
   logic st_rd; // Last cycle read the status port
   logic next_st_rd;
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);
   // Word counter; an opcode write restarts it so each block is counted alone
   always_comb begin
      next_data_rd = rd && (addr == `TF_DATA);
      next_st_rd = rd && (addr == `TF_CMD);
      next_data_cnt = data_cnt;
      if (wr && (addr == `TF_CMD)) begin
         next_data_cnt = 9'h000;
      end else if (rvalid && data_rd) begin
         next_data_cnt = data_cnt + 9'h001;
      end
   end
   // Register the helper state
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         data_cnt <= 9'h000;
         data_rd <= 1'b0;
         st_rd <= 1'b0;
      end else begin
         data_cnt <= next_data_cnt;
         data_rd <= next_data_rd;
         st_rd <= next_st_rd;
      end
   end
   AST_RD_ANSWER: assert property (rd |=> rvalid)
      else $error("read strobe not answered next cycle");
   AST_NO_SPURIOUS: assert property (!rd |=> !rvalid)
      else $error("read data valid without a read");
   AST_OPC_CODE: assert property (wr && addr == `TF_CMD |-> wdata[7:0] == `OPC_OVERLAY)
      else $error("wrong opcode written");
   AST_LOAD_ORDER: assert property (wr && addr == `TF_CMD |-> $past(wr && addr == `TF_UNIT)
      && $past(wr && addr == `TF_FEATURE, 2) && $past(wdata[7:0], 2) == `FEAT_IDENTIFY)
      else $error("feature and unit not loaded before opcode");
   AST_DONE_READY: assert property (rvalid && st_rd && !rdata[7] && !rdata[3] |->
      rdata[6] && (rdata[0] || !rdata[5]))
      else $error("completion status lacks ready or shows fault");
   AST_ERR_STATE: assert property (rvalid && st_rd && rdata[0] |-> rdata[6] && !rdata[3] && !rdata[7])
      else $error("error status with busy or data request");
   AST_BLOCK_LEN: assert property (rvalid && data_rd |-> data_cnt < 9'h100)
      else $error("more than one block delivered");
   AST_DRQ_DROPS: assert property (rvalid && st_rd && data_cnt == 9'h100 |-> !rdata[3])
      else $error("data request still set after full block");
   AST_REVISION: assert property (rvalid && data_rd && data_cnt == 9'h000 |-> rdata == 16'h0001)
      else $error("word 0 not the revision value");
   AST_FEAT_RSV: assert property (rvalid && data_rd && data_cnt == 9'h007 |-> rdata[15:9] == 7'h00)
      else $error("capability word reserved bits set");
   AST_RESERVED: assert property (rvalid && data_rd && data_cnt >= 9'h008 && data_cnt <= 9'h0FE
      |-> rdata == 16'h0000)
      else $error("reserved word not zero");
   AST_SIGNATURE: assert property (rvalid && data_rd && data_cnt == 9'h0FF |-> rdata[7:0] == `SIGNATURE)
      else $error("signature byte wrong");
endmodule // config_overlay_identify_cmd_props
`default_nettype wire

/* File: tb/config_overlay_identify_cmd_tb.sv */
// Bench: software drives the host end over Avalon; a second device is driven directly.
// Assumes the rtl files and the link interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "overlay_defs.svh"
module config_overlay_identify_cmd_tb;
   logic clk_sys = 1'b0; // 25 MHz system clock
   logic rst = 1'b1; // Synchronous reset
   logic ce = 1'b1; // Clock enable, kept on
   logic pw1 = 1'b1; // Power-up pulse, first device
   logic pw2 = 1'b1; // Power-up pulse, second device
   logic sup = 1'b1; // Feature set present, first device
   logic fault = 1'b0; // Device fault, first device
   logic [15:0] mdma = 16'h0000;
   logic [15:0] udma = 16'h0000;
   logic [15:0] feat = 16'h0000;
   logic [63:0] nmax = 64'h0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, irq, set_req1, frozen1, set_req2, frozen2;
   int err_count = 0;
   int cmp_count = 0;
   int set_cnt = 0; // Set requests seen on the second device
   logic [15:0] words[$]; // Data words seen on the first link
   logic prd = 1'b0; // Previous cycle read the data port
   logic unit_seen = 1'b0; // Unit bit last written on the first link
   tf_link_if link1();
   tf_link_if link2();
   overlay_host overlay_host_i (.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq), .link(link1.host));
   overlay_device overlay_device_i (.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .POWER_UP(pw1), .SUPPORTED(sup),
      .FAULT(fault), .FULL_MDMA(mdma), .FULL_UDMA(udma), .FULL_FEAT(feat), .NATIVE_MAX(nmax),
      .SET_REQ(set_req1), .FROZEN(frozen1), .link(link1.device));
   // Second device faces the bench so that freeze and set can be commanded
   overlay_device overlay_device_b_i (.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .POWER_UP(pw2), .SUPPORTED(1'b1),
      .FAULT(1'b0), .FULL_MDMA(mdma), .FULL_UDMA(udma), .FULL_FEAT(feat), .NATIVE_MAX(nmax),
      .SET_REQ(set_req2), .FROZEN(frozen2), .link(link2.device));
   config_overlay_identify_cmd_props props_i (.CLK_SYS(clk_sys), .RST(rst), .addr(link1.addr), .wr(link1.wr),
      .rd(link1.rd), .wdata(link1.wdata), .rdata(link1.rdata), .rvalid(link1.rvalid));
   // Clock
   always #20 clk_sys = ~clk_sys;
   // Link monitor: collect data words and the unit bit, count set pulses
   always @(posedge clk_sys) begin
      prd <= link1.rd && link1.addr == `TF_DATA;
      if (link1.rvalid === 1'b1 && prd) begin
         words.push_back(link1.rdata);
      end
      if (link1.wr === 1'b1 && link1.addr == `TF_UNIT) begin
         unit_seen <= link1.wdata[`UNIT_SEL_BIT];
      end
      if (set_req2 === 1'b1) begin
         set_cnt <= set_cnt + 1;
      end
   end
   // Expected structure word; recursion builds the checksum from words 0-254
   function automatic logic [15:0] exp_word(input int i);
      logic [7:0] s;
      logic [15:0] w;
      if (i == 0) return 16'h0001;
      if (i == 1) return mdma & 16'h0007;
      if (i == 2) return udma & 16'h003F;
      if (i >= 3 && i <= 6) return nmax[16*(i-3) +: 16];
      if (i == 7) return feat & 16'h01FF;
      if (i != 255) return 16'h0000;
      s = 8'hA5;
      for (int k = 0; k < 255; k++) begin
         w = exp_word(k);
         s = s + w[7:0] + w[15:8];
      end
      return {8'h00 - s, 8'hA5};
   endfunction
   // Expected completion status
   function automatic logic [7:0] exp_status(input logic su, input logic fa);
      return su ? 8'h40 : (fa ? 8'h61 : 8'h41);
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Avalon cycles: hold the request until waitrequest is sampled low
   task automatic av_wr(input logic [3:0] a, input logic [31:0] v);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= 1'b1;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk_sys);
      end
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk_sys);
      end
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Direct link cycles for the second device: feature, unit, opcode on consecutive edges
   task automatic l2_cmd(input logic [7:0] f, input logic [7:0] u);
      link2.addr <= `TF_FEATURE;
      link2.wdata <= {8'h00, f};
      link2.wr <= 1'b1;
      @(posedge clk_sys);
      link2.addr <= `TF_UNIT;
      link2.wdata <= {8'h00, u};
      @(posedge clk_sys);
      link2.addr <= `TF_CMD;
      link2.wdata <= {8'h00, `OPC_OVERLAY};
      @(posedge clk_sys);
      link2.wr <= 1'b0;
   endtask
   task automatic l2_rd(input logic [2:0] a, output logic [15:0] r);
      link2.addr <= a;
      link2.rd <= 1'b1;
      @(posedge clk_sys);
      link2.rd <= 1'b0;
      @(posedge clk_sys);
      r = link2.rdata;
   endtask
   task automatic l2_poll(output logic [15:0] r);
      r = 16'h0080;
      while (r[7] !== 1'b0) begin
         l2_rd(`TF_CMD, r);
      end
   endtask
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Watchdog, well beyond the expected run length
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_count++;
      test_done();
   end
   // Main sequence
   initial begin
      logic [31:0] d;
      logic [15:0] r;
      logic [7:0] bsum;
      logic sv, fv, u;
      int n;
      link2.addr = 3'h0;
      link2.wr = 1'b0;
      link2.rd = 1'b0;
      link2.wdata = 16'h0000;
      n = $urandom(32'hA7B02473);
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      pw1 <= 1'b0;
      pw2 <= 1'b0;
      @(posedge clk_sys);
      av_rd(4'h2, d);
      check("unmapped", d, 32'h0);
      // Normal, fault ignored, unsupported, unsupported with fault; last run masked
      for (int t = 0; t < 4; t++) begin
         sv = (t < 2);
         fv = t[0];
         u = 1'($urandom);
         sup <= sv;
         fault <= fv;
         mdma <= 16'($urandom);
         udma <= 16'($urandom);
         feat <= 16'($urandom);
         nmax <= {$urandom, $urandom};
         words.delete();
         av_wr(`HR_IRQ_MASK, (t == 3) ? 32'h0 : 32'h3);
         av_wr(`HR_CTRL, {30'h0, u, 1'b1});
         d = 32'h1;
         while (d[0] !== 1'b0) begin
            av_rd(`HR_CTRL, d);
         end
         check("ctrl unit", 32'(d[1]), 32'(u));
         av_rd(`HR_STATUS, d);
         check("status", 32'(d[7:0]), 32'(exp_status(sv, fv)));
         check("word count", 32'(d[16:8]), sv ? 32'h100 : 32'h0);
         check("words seen", 32'(words.size()), sv ? 32'h100 : 32'h0);
         bsum = 8'h00;
         foreach (words[k]) begin
            check("word", 32'(words[k]), 32'(exp_word(k)));
            bsum = bsum + words[k][7:0] + words[k][15:8];
         end
         check("byte sum", 32'(bsum), 32'h0);
         check("unit bit", 32'(unit_seen), 32'(u));
         check("irq level", 32'(irq), (t == 3) ? 32'h0 : 32'h1);
         av_rd(`HR_IRQ_STAT, d);
         check("irq status", 32'(d[1:0]), 32'h1);
         av_wr(`HR_IRQ_STAT, 32'h3);
         check("irq cleared", 32'(irq), 32'h0);
         $display("identify test %0d done", t);
      end
      // Freeze lock on the second device, then identify must abort
      l2_cmd(`FEAT_FREEZE, 8'h10);
      l2_poll(r);
      check("frozen", 32'(frozen2), 32'h1);
      l2_cmd(`FEAT_IDENTIFY, 8'h10);
      l2_poll(r);
      check("abort status", 32'(r[7:0]), 32'h41);
      l2_rd(3'h2, r);
      check("abort bit", 32'(r[7:0]), 32'h04);
      l2_rd(`TF_UNIT, r);
      check("unit echo", 32'(r[`UNIT_SEL_BIT]), 32'h1);
      // A reset must not clear the lock; only power-up does
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check("frozen after reset", 32'(frozen2), 32'h1);
      pw2 <= 1'b1;
      @(posedge clk_sys);
      pw2 <= 1'b0;
      @(posedge clk_sys);
      check("frozen after power-up", 32'(frozen2), 32'h0);
      // Restore completes cleanly; an unknown sub-command aborts
      l2_cmd(`FEAT_RESTORE, 8'h00);
      l2_poll(r);
      check("restore status", 32'(r[7:0]), 32'h40);
      l2_cmd(8'h5A, 8'h00);
      l2_poll(r);
      check("unknown abort", 32'(r[7:0]), 32'h41);
      check("first not frozen", 32'(frozen1), 32'h0);
      check("no set on first", 32'(set_req1), 32'h0);
      l2_cmd(`FEAT_SET, 8'h00);
      repeat (3) @(posedge clk_sys);
      check("set requests", 32'(set_cnt), 32'h1);
      $display("freeze and set test done");
      test_done();
   end
endmodule // config_overlay_identify_cmd_tb
`default_nettype wire
